// File: pmc_ctrl.sv
// Supply monitors, reset stretch, synthesized clock sequencing and DAC / reference gating.
// Assumes all inputs are synchronous to clk_sys; supply comparators arrive as levels.
`timescale 1ns/1ps
`default_nettype none

module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int          RST_STRETCH_TICKS = PMC_RST_STRETCH_TICKS,
    parameter int          STARTUP_TICKS     = PMC_STARTUP_TICKS,
    parameter int          GRACE_TICKS       = PMC_GRACE_TICKS,
    parameter logic [31:0] SYNTH_INC         = 32'(PMC_SYNTH_INC)
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire logic                 crystal_in,
    output logic                      crystal_out,
    input  wire logic                 avdd_below_1v8,
    input  wire logic                 avdd_below_2v7,
    input  wire pmc_mode_t            power_mode,
    input  wire logic                 ctrl_wr,
    input  wire pmc_ctrl_t            ctrl_wdata,
    output pmc_ctrl_t                 ctrl_q,
    input  wire logic [1:0]           dac_wr,
    input  wire logic [PMC_DAC_W-1:0] dac_wdata,
    output logic [PMC_DAC_W-1:0]      dac_one_output,
    output logic                      dac_one_oe,
    output logic [PMC_DAC_W-1:0]      dac_two_output,
    output logic                      dac_two_oe,
    output logic                      vref_on,
    input  wire logic                 status_rd,
    output pmc_status_t               status_q,
    output logic                      reset_out_n,
    output logic                      synth_clock_out,
    output logic                      synth_running
);

    // ==========================================================
    // Helpers
    function automatic logic [PMC_TICK_W-1:0] dec_sat(input logic [PMC_TICK_W-1:0] v);
        dec_sat = (v == '0) ? '0 : v - 1'b1;
    endfunction : dec_sat

    localparam logic [PMC_TICK_W-1:0] STRETCH_LOAD = PMC_TICK_W'(RST_STRETCH_TICKS);
    localparam logic [PMC_TICK_W-1:0] STARTUP_LOAD = PMC_TICK_W'(STARTUP_TICKS);
    localparam logic [PMC_TICK_W-1:0] GRACE_LOAD   = PMC_TICK_W'(GRACE_TICKS);

    typedef enum logic [1:0] {SYN_OFF, SYN_WARMUP, SYN_ON, SYN_GRACE} pmc_syn_t;

    // ==========================================================
    // Declarations
    logic                    xtal_prev_ff;
    logic                    xtal_tick;
    logic                    crystal_out_ff;
    pmc_mode_t               mode_prev_ff;
    logic                    sleep_entry;
    logic                    wake_entry;
    logic                    in_sleep;
    pmc_ctrl_t               ctrl_ff;
    pmc_ctrl_t               nxt_ctrl;
    logic [PMC_DAC_W-1:0]    dac_one_ff;
    logic [PMC_DAC_W-1:0]    dac_two_ff;
    logic                    rst_mon_active;
    logic                    rst_trip;
    logic                    low_trip;
    logic [PMC_TICK_W-1:0]   stretch_ff;
    logic                    reset_out_n_ff;
    pmc_status_t             status_ff;
    pmc_status_t             nxt_status;
    pmc_syn_t                syn_state_ff;
    pmc_syn_t                nxt_syn_state;
    logic [PMC_TICK_W-1:0]   syn_cnt_ff;
    logic [PMC_TICK_W-1:0]   nxt_syn_cnt;
    logic                    gate_want;
    logic [31:0]             phase_ff;
    logic                    raw_ff;
    logic                    gate_ff;
    logic                    gate_prev_ff;
    logic                    out_ff;
    logic                    clock_enabled_pulse;

    // ==========================================================
    // Crystal tick
    // Crystal input counts as synchronous, so a single flop suffices for edges
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            xtal_prev_ff   <= 1'b0;
            crystal_out_ff <= 1'b1;
        end
        else
        begin
            xtal_prev_ff   <= crystal_in;
            crystal_out_ff <= ~crystal_in;
        end
    end

    assign xtal_tick   = crystal_in & ~xtal_prev_ff;
    assign crystal_out = crystal_out_ff;

    // ==========================================================
    // Power mode tracking
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_prev_ff <= PMC_MODE_RST;
        end
        else
        begin
            mode_prev_ff <= power_mode;
        end
    end

    assign in_sleep    = (power_mode == PMC_SLEEP);
    assign sleep_entry = in_sleep && (mode_prev_ff != PMC_SLEEP);
    assign wake_entry  = ((power_mode == PMC_IDLE) || (power_mode == PMC_RUN))
                         && (mode_prev_ff != PMC_IDLE) && (mode_prev_ff != PMC_RUN);

    // ==========================================================
    // Control bits
    // Automatic mode actions override a host write in the same cycle
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (ctrl_wr)
        begin
            nxt_ctrl = ctrl_wdata;
        end
        if (wake_entry)
        begin
            nxt_ctrl.dac_one_power = 1'b1;
            nxt_ctrl.dac_two_power = 1'b1;
        end
        if (sleep_entry)
        begin
            nxt_ctrl.synth_enable   = 1'b0;
            nxt_ctrl.supply_hold_en = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_ff <= PMC_CTRL_RST;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    assign ctrl_q  = ctrl_ff;
    assign vref_on = ctrl_ff.vref_power;

    // ==========================================================
    // DAC codes and output drive
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            dac_one_ff <= '0;
            dac_two_ff <= '0;
        end
        else
        begin
            if (dac_wr[0])
            begin
                dac_one_ff <= dac_wdata;
            end
            if (dac_wr[1])
            begin
                dac_two_ff <= dac_wdata;
            end
        end
    end

    // Output enable low means the analog pin floats
    assign dac_one_output = dac_one_ff;
    assign dac_two_output = dac_two_ff;
    assign dac_one_oe     = ctrl_ff.dac_one_power;
    assign dac_two_oe     = ctrl_ff.dac_two_power;

    // ==========================================================
    // Reset monitor and stretch
    assign rst_mon_active = (!ctrl_ff.monitor_select && ctrl_ff.low_supply_monitor_en)
                            || (ctrl_ff.monitor_select && ctrl_ff.alt_monitor_en);
    assign rst_trip       = rst_mon_active
                            && (ctrl_ff.reset_thresh_high ? avdd_below_2v7 : avdd_below_1v8);

    // Power-on starts with a full stretch, like a supply recovering from zero
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            stretch_ff     <= STRETCH_LOAD;
            reset_out_n_ff <= 1'b0;
        end
        else
        begin
            if (rst_trip)
            begin
                stretch_ff     <= STRETCH_LOAD;
                reset_out_n_ff <= 1'b0;
            end
            else
            begin
                if (xtal_tick)
                begin
                    stretch_ff <= dec_sat(stretch_ff);
                end
                reset_out_n_ff <= (stretch_ff == '0);
            end
        end
    end

    assign reset_out_n = reset_out_n_ff;

    // ==========================================================
    // Status flags
    assign low_trip = !in_sleep && avdd_below_2v7;

    // Each flag: set term last, so a coinciding read never loses an event
    always_comb
    begin
        nxt_status = status_ff;
        if (status_rd && !rst_trip)
        begin
            nxt_status.reset_flag = 1'b0;
        end
        if (rst_trip)
        begin
            nxt_status.reset_flag = 1'b1;
        end
        if (status_rd && (in_sleep || !avdd_below_2v7))
        begin
            nxt_status.low_supply_flag = 1'b0;
        end
        if (low_trip)
        begin
            nxt_status.low_supply_flag = 1'b1;
        end
        if (status_rd)
        begin
            nxt_status.clock_ready = 1'b0;
        end
        if (clock_enabled_pulse)
        begin
            nxt_status.clock_ready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            status_ff <= PMC_STATUS_RST;
        end
        else
        begin
            status_ff <= nxt_status;
        end
    end

    assign status_q = status_ff;

    // ==========================================================
    // Synthesizer sequencing
    // Reset output is not an off condition once running
    always_comb
    begin
        nxt_syn_state = syn_state_ff;
        nxt_syn_cnt   = syn_cnt_ff;
        unique case (syn_state_ff)
            SYN_OFF:
            begin
                if (ctrl_ff.synth_enable && !in_sleep && !avdd_below_2v7 && reset_out_n_ff)
                begin
                    nxt_syn_state = SYN_WARMUP;
                    nxt_syn_cnt   = STARTUP_LOAD;
                end
            end
            SYN_WARMUP:
            begin
                if (!ctrl_ff.synth_enable || in_sleep)
                begin
                    nxt_syn_state = SYN_OFF;
                end
                else if (syn_cnt_ff == '0)
                begin
                    nxt_syn_state = SYN_ON;
                end
                else if (xtal_tick)
                begin
                    nxt_syn_cnt = dec_sat(syn_cnt_ff);
                end
            end
            SYN_ON:
            begin
                if (!ctrl_ff.synth_enable || sleep_entry || in_sleep)
                begin
                    nxt_syn_state = SYN_GRACE;
                    nxt_syn_cnt   = GRACE_LOAD;
                end
            end
            SYN_GRACE:
            begin
                if (syn_cnt_ff == '0)
                begin
                    nxt_syn_state = SYN_OFF;
                end
                else if (xtal_tick)
                begin
                    nxt_syn_cnt = dec_sat(syn_cnt_ff);
                end
            end
        endcase
    end

    // Power-up enters warm-up directly: the synthesizer starts enabled
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            syn_state_ff <= SYN_WARMUP;
            syn_cnt_ff   <= STARTUP_LOAD;
        end
        else
        begin
            syn_state_ff <= nxt_syn_state;
            syn_cnt_ff   <= nxt_syn_cnt;
        end
    end

    assign gate_want     = (syn_state_ff == SYN_ON) || (syn_state_ff == SYN_GRACE);
    assign synth_running = (syn_state_ff != SYN_OFF);

    // ==========================================================
    // Clock generation and gating
    // Phase step is the crystal rate times 75; jitter is one system period
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_ff <= '0;
            raw_ff   <= 1'b0;
        end
        else
        begin
            phase_ff <= phase_ff + SYNTH_INC;
            raw_ff   <= phase_ff[31];
        end
    end

    // Gate only moves while the raw clock is low, so every pulse is whole
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            gate_ff      <= 1'b0;
            gate_prev_ff <= 1'b0;
            out_ff       <= 1'b0;
        end
        else
        begin
            if (!raw_ff)
            begin
                gate_ff <= gate_want;
            end
            gate_prev_ff <= gate_ff;
            out_ff       <= raw_ff & gate_ff;
        end
    end

    assign clock_enabled_pulse = gate_ff & ~gate_prev_ff;
    assign synth_clock_out     = out_ff;

endmodule : pmc_ctrl

`default_nettype wire

// File: pmc_pkg.sv
// Constants, types and timing for the supply monitor / clock / power controller.
// Assumes a 100 MHz system clock and a 32.768 kHz crystal seen as a synchronous input.
// Operation
// - Supply below reset threshold drives reset output low and sets reset_flag.
// - Reset threshold is selectable between the 1.8V and 2.7V trip levels.
// - After power-up the reset threshold selection defaults to the 2.7V level.
// - Reset output stays low about 1.54 s after the supply recovers.
// - Status read clears reset_flag only when the supply is above threshold.
// - Reset monitor active when selector 0 with low-supply enable, or selector 1 with alternate.
// - In Run, Idle or Standby, supply below 2.7V sets low_supply_flag.
// - Outside Sleep, a status read clears low_supply_flag only when the supply is above 2.7V.
// - In Sleep the low-supply monitor is off and its flag holds.
// - In Sleep a status read clears low_supply_flag unconditionally.
// - Each DAC powers down on its own; a powered-down output goes high impedance.
// - Entering Idle or Run powers both DACs up automatically.
// - Clearing vref_power powers down the internal reference.
// - The synthesized clock is derived as a fixed multiple of the crystal clock.
// - After a synthesizer off command the output toggles 1.95 ms, then holds low.
// - The synthesizer runs in every power mode except Sleep.
// - Reactivation needs supply above low level, reset released and synth_enable set.
// - The clock output is enabled 31.25 ms after activation, off before.
// - The synthesizer starts enabled at power-up; reset does not stop it.
// - Reset asserting while running keeps the synthesizer and its output running.
// - Entering Sleep clears synth_enable and supply_hold_en.
// - Clock-ready status sets once the output is enabled; a status read clears it.
package pmc_pkg;

    // ==========================================================
    // Timing
    localparam longint PMC_SYS_HZ          = 64'd100000000;
    localparam longint PMC_XTAL_HZ         = 64'd32768;
    localparam longint PMC_SYNTH_HZ        = 64'd2457600;
    localparam longint PMC_RST_STRETCH_US  = 64'd1540000;
    localparam longint PMC_STARTUP_US      = 64'd31250;
    localparam longint PMC_GRACE_US        = 64'd1950;
    // Least times round up, the grace period (a longest time) rounds down
    localparam int PMC_RST_STRETCH_TICKS = int'((PMC_RST_STRETCH_US * PMC_XTAL_HZ + 64'd999999) / 64'd1000000);
    localparam int PMC_STARTUP_TICKS     = int'((PMC_STARTUP_US * PMC_XTAL_HZ + 64'd999999) / 64'd1000000);
    localparam int PMC_GRACE_TICKS       = int'((PMC_GRACE_US * PMC_XTAL_HZ) / 64'd1000000);
    // Phase step so the accumulator top bit runs at the synthesized rate
    localparam longint PMC_SYNTH_INC     = (PMC_SYNTH_HZ * 64'h100000000) / PMC_SYS_HZ;
    localparam int     PMC_TICK_W        = 16;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {PMC_SLEEP, PMC_STANDBY, PMC_IDLE, PMC_RUN} pmc_mode_t;

    typedef struct packed {
        logic monitor_select;
        logic low_supply_monitor_en;
        logic alt_monitor_en;
        logic reset_thresh_high;
        logic dac_one_power;
        logic dac_two_power;
        logic vref_power;
        logic synth_enable;
        logic supply_hold_en;
    } pmc_ctrl_t;

    typedef struct packed {
        logic clock_ready;
        logic low_supply_flag;
        logic reset_flag;
    } pmc_status_t;

    // ==========================================================
    // Reset values
    localparam pmc_ctrl_t   PMC_CTRL_RST   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    localparam pmc_status_t PMC_STATUS_RST = '{1'b0, 1'b0, 1'b0};
    localparam pmc_mode_t   PMC_MODE_RST   = PMC_RUN;
    localparam int          PMC_DAC_W      = 10;

endpackage : pmc_pkg

// File: pmc_ctrl_monitor.sv
// Concurrent checks on the supply monitor / clock / power controller ports.
// Assumes it is bound onto pmc_ctrl; every signal belongs to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pmc_ctrl_monitor
    import pmc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        avdd_below_1v8,
    input wire logic        avdd_below_2v7,
    input wire pmc_mode_t   power_mode,
    input wire logic        ctrl_wr,
    input wire pmc_ctrl_t   ctrl_wdata,
    input wire pmc_ctrl_t   ctrl_q,
    input wire logic        dac_one_oe,
    input wire logic        dac_two_oe,
    input wire logic        vref_on,
    input wire logic        status_rd,
    input wire pmc_status_t status_q,
    input wire logic        reset_out_n,
    input wire logic        synth_clock_out,
    input wire logic        synth_running
);
    // ==========================================================
    // Helpers
    logic       trip;
    logic       awake;
    logic [7:0] off_cnt_ff;

    assign trip  = (ctrl_q.monitor_select ? ctrl_q.alt_monitor_en : ctrl_q.low_supply_monitor_en)
                   && (ctrl_q.reset_thresh_high ? avdd_below_2v7 : avdd_below_1v8);
    assign awake = (power_mode == PMC_IDLE) || (power_mode == PMC_RUN);

    // Half a raw period is about 20 cycles, so 60 covers the low-phase cutoff
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            off_cnt_ff <= 8'h00;
        else if (synth_running)
            off_cnt_ff <= 8'h00;
        else if (off_cnt_ff != 8'hff)
            off_cnt_ff <= off_cnt_ff + 8'h01;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Assertions
    chk_trip_reset_low: assert property (trip |=> !reset_out_n && status_q.reset_flag)
        else $error("reset output or flag missed a trip");
    chk_rst_read_clear: assert property (status_rd && !trip |=> !status_q.reset_flag)
        else $error("reset flag kept after clearing read");
    chk_low_flag_set: assert property (power_mode != PMC_SLEEP && avdd_below_2v7 |=> status_q.low_supply_flag)
        else $error("low supply flag not set");
    chk_sleep_flag_hold: assert property (power_mode == PMC_SLEEP && !status_rd |=>
        status_q.low_supply_flag == $past(status_q.low_supply_flag))
        else $error("low supply flag moved in sleep");
    chk_sleep_read_clr: assert property (power_mode == PMC_SLEEP && status_rd |=> !status_q.low_supply_flag)
        else $error("sleep read left low supply flag");
    chk_wake_dac_on: assert property (awake && !$past(awake) && $past(rstn) |=> dac_one_oe && dac_two_oe)
        else $error("dacs not powered on wake");
    chk_sleep_clr_en: assert property (power_mode == PMC_SLEEP && $past(power_mode) != PMC_SLEEP && $past(rstn)
        |=> !ctrl_q.synth_enable && !ctrl_q.supply_hold_en)
        else $error("sleep entry kept enables");
    chk_vref_write: assert property (ctrl_wr |=> vref_on == $past(ctrl_wdata.vref_power))
        else $error("reference power not written");
    chk_reset_keeps_clk: assert property ($fell(reset_out_n) && synth_running && ctrl_q.synth_enable
        && power_mode != PMC_SLEEP |=> synth_running [*8])
        else $error("synthesizer stopped by reset");
    chk_off_clock_low: assert property (off_cnt_ff > 8'd60 |-> !synth_clock_out)
        else $error("clock output active while off");

    cover property ($rose(reset_out_n));
    cover property ($rose(synth_clock_out));
    cover property (status_rd && status_q.reset_flag);
endmodule : pmc_ctrl_monitor

bind pmc_ctrl pmc_ctrl_monitor pmc_ctrl_monitor_i (.*);

`default_nettype wire

// File: pmc_host_model.sv
// Host side: counts rising edges of the synthesized clock it runs from.
// Assumes the clock output is slow enough to be sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pmc_host_model
(
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    input  wire logic   synth_clock_out,
    output logic [15:0] edge_cnt
);
    // ==========================================================
    // Edge counter
    logic seen_ff;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            seen_ff  <= 1'b0;
            edge_cnt <= 16'h0000;
        end
        else
        begin
            seen_ff <= synth_clock_out;
            if (synth_clock_out && !seen_ff)
                edge_cnt <= edge_cnt + 16'h0001;
        end
    end
endmodule : pmc_host_model

`default_nettype wire

// File: test_supply_monitor_clock_power_ctrl.sv
// Directed bench for the supply monitor / clock / power controller.
// Assumes short tick parameters and a crystal tick every 20 clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none

module test_supply_monitor_clock_power_ctrl
    import pmc_pkg::*;
;
    // ==========================================================
    // Signals
    logic                 clk_sys        = 1'b0;
    logic                 rstn           = 1'b0;
    logic                 crystal_in     = 1'b0;
    logic                 avdd_below_1v8 = 1'b0;
    logic                 avdd_below_2v7 = 1'b0;
    pmc_mode_t            power_mode     = PMC_RUN;
    logic                 ctrl_wr        = 1'b0;
    pmc_ctrl_t            ctrl_wdata     = PMC_CTRL_RST;
    logic [1:0]           dac_wr         = 2'b00;
    logic [PMC_DAC_W-1:0] dac_wdata      = 10'h000;
    logic                 status_rd      = 1'b0;
    pmc_ctrl_t            ctrl_q;
    logic [PMC_DAC_W-1:0] dac_one_output;
    logic [PMC_DAC_W-1:0] dac_two_output;
    logic                 dac_one_oe;
    logic                 dac_two_oe;
    logic                 vref_on;
    pmc_status_t          status_q;
    logic                 reset_out_n;
    logic                 synth_clock_out;
    logic                 synth_running;
    logic [15:0]          edge_cnt;
    logic [15:0]          e0;
    logic [15:0]          e1;
    logic [3:0]           xtal_div       = 4'h0;
    pmc_ctrl_t            c;
    pmc_status_t          s;
    int                   fails          = 0;
    int                   samples_checked = 0;
    int                   cycles         = 0;

    pmc_ctrl #(.RST_STRETCH_TICKS(8), .STARTUP_TICKS(4), .GRACE_TICKS(3)) pmc_ctrl_i (.*, .crystal_out());

    pmc_host_model pmc_host_model_i (.*);

    // ==========================================================
    // Clock, crystal and hang guard
    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        xtal_div <= (xtal_div == 4'h9) ? 4'h0 : xtal_div + 4'h1;
        if (xtal_div == 4'h9)
            crystal_in <= ~crystal_in;
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            summarize();
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_n

    task automatic set_supply(input logic b18, input logic b27);
        @(posedge clk_sys);
        avdd_below_1v8 <= b18;
        avdd_below_2v7 <= b27;
        #1;
    endtask : set_supply

    task automatic wr_ctrl(input pmc_ctrl_t d);
        @(posedge clk_sys);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= d;
        @(posedge clk_sys);
        ctrl_wr    <= 1'b0;
        #1;
    endtask : wr_ctrl

    // Host loads a full 10-bit code into one or both converters
    task automatic wr_dac(input logic [1:0] sel, input logic [PMC_DAC_W-1:0] code);
        @(posedge clk_sys);
        dac_wr    <= sel;
        dac_wdata <= code;
        @(posedge clk_sys);
        dac_wr    <= 2'b00;
        #1;
    endtask : wr_dac

    // Returns the flags as left after the read
    task automatic rd_status(output pmc_status_t r);
        @(posedge clk_sys);
        status_rd <= 1'b1;
        @(posedge clk_sys);
        status_rd <= 1'b0;
        #1;
        r = status_q;
    endtask : rd_status

    task automatic wait_rel();
        int n;
        n = 0;
        while (reset_out_n !== 1'b1 && n < 400)
        begin
            wait_n(1);
            n++;
        end
        chk("reset_out_n", 1'b1, reset_out_n);
    endtask : wait_rel

    task automatic summarize();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // ==========================================================
    // Sequence
    initial
    begin
        c = PMC_CTRL_RST;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        wait_n(1);
        chk("thresh_high", 1'b1, ctrl_q.reset_thresh_high);
        chk("synth_en", 1'b1, ctrl_q.synth_enable);
        wait_n(40);
        chk("early_edges", 16'h0000, edge_cnt);
        wait_n(60);
        chk("stretch", 1'b0, reset_out_n);
        wait_rel();
        chk("edges_up", 1'b1, edge_cnt != 16'h0000);
        chk("ready", 1'b1, status_q.clock_ready);
        rd_status(s);
        chk("ready_clr", 1'b0, s.clock_ready);
        set_supply(1'b0, 1'b1);
        e0 = edge_cnt;
        wait_n(5);
        chk("dip_reset", 1'b0, reset_out_n);
        chk("dip_rflag", 1'b1, status_q.reset_flag);
        chk("dip_lflag", 1'b1, status_q.low_supply_flag);
        wait_n(100);
        chk("edges_in_rst", 1'b1, edge_cnt != e0);
        rd_status(s);
        chk("rflag_held", 1'b1, s.reset_flag);
        chk("lflag_held", 1'b1, s.low_supply_flag);
        set_supply(1'b0, 1'b0);
        rd_status(s);
        chk("rflag_clr", 1'b0, s.reset_flag);
        chk("lflag_clr", 1'b0, s.low_supply_flag);
        wait_rel();
        c.reset_thresh_high = 1'b0;
        wr_ctrl(c);
        set_supply(1'b0, 1'b1);
        wait_n(5);
        chk("low_thr_hold", 1'b1, reset_out_n);
        set_supply(1'b1, 1'b1);
        wait_n(2);
        chk("low_thr_trip", 1'b0, reset_out_n);
        set_supply(1'b0, 1'b0);
        wait_rel();
        c.monitor_select = 1'b1;
        wr_ctrl(c);
        set_supply(1'b1, 1'b0);
        wait_n(5);
        chk("alt_off", 1'b1, reset_out_n);
        c.alt_monitor_en = 1'b1;
        wr_ctrl(c);
        wait_n(2);
        chk("alt_on", 1'b0, reset_out_n);
        set_supply(1'b0, 1'b0);
        wait_rel();
        rd_status(s);
        c.monitor_select = 1'b0;
        c.alt_monitor_en = 1'b0;
        wr_dac(2'b01, 10'h3a5);
        chk("dac_one", 16'h03a5, dac_one_output);
        wr_dac(2'b10, 10'h05a);
        chk("dac_two", 16'h005a, dac_two_output);
        chk("dac_one_kept", 16'h03a5, dac_one_output);
        c.dac_one_power = 1'b1;
        c.vref_power = 1'b0;
        wr_ctrl(c);
        chk("oe_one", 1'b1, dac_one_oe);
        chk("oe_two", 1'b0, dac_two_oe);
        chk("vref_on", 1'b0, vref_on);
        @(posedge clk_sys);
        power_mode <= PMC_STANDBY;
        set_supply(1'b0, 1'b1);
        wait_n(2);
        chk("stby_lflag", 1'b1, status_q.low_supply_flag);
        @(posedge clk_sys);
        power_mode <= PMC_SLEEP;
        e0 = edge_cnt;
        wait_n(3);
        chk("sleep_synth", 1'b0, ctrl_q.synth_enable);
        chk("sleep_hold", 1'b0, ctrl_q.supply_hold_en);
        wait_n(60);
        chk("grace_edges", 1'b1, edge_cnt != e0);
        wait_n(110);
        e1 = edge_cnt;
        wait_n(100);
        chk("sleep_edges", e1, edge_cnt);
        chk("sleep_clk_low", 1'b0, synth_clock_out);
        set_supply(1'b0, 1'b0);
        wait_n(3);
        chk("sleep_lhold", 1'b1, status_q.low_supply_flag);
        set_supply(1'b0, 1'b1);
        rd_status(s);
        chk("sleep_rd_clr", 1'b0, s.low_supply_flag);
        wait_n(5);
        chk("sleep_no_set", 1'b0, status_q.low_supply_flag);
        @(posedge clk_sys);
        power_mode <= PMC_RUN;
        wait_n(2);
        chk("wake_oe_one", 1'b1, dac_one_oe);
        chk("wake_oe_two", 1'b1, dac_two_oe);
        wr_ctrl(c);
        wait_n(200);
        chk("no_restart", e1, edge_cnt);
        set_supply(1'b0, 1'b0);
        wait_n(300);
        chk("restart", 1'b1, edge_cnt != e1);
        summarize();
    end
endmodule : test_supply_monitor_clock_power_ctrl

`default_nettype wire
